//--- logic/tx_config_defines.vh
// register offsets, field positions, reset values and preset tables of the config bank
`ifndef TX_CONFIG_DEFINES_VH
`define TX_CONFIG_DEFINES_VH

// register offsets
`define ADDR_IDENTIFICATION 8'h00
`define ADDR_CONFIG_GENERAL 8'h01
`define ADDR_CONFIG_CLOCK_AND_MATCH 8'h02
`define ADDR_CONFIG_EMULATION 8'h03

// reset values (zero: open shaping pin with pulse extension, other features off, normal drive, low bandwidth)
`define RST_CONFIG_GENERAL 8'h00
`define RST_CONFIG_CLOCK_AND_MATCH 8'h00
`define RST_CONFIG_EMULATION 8'h00

// writable mask of config_general: bit 7 is unused
`define MASK_CONFIG_GENERAL 8'h7f

// config_general fields
`define GEN_DRIVE_BOOST_BIT 6
`define GEN_PLL_BW_BIT 5
`define GEN_SHAPE_HI 4
`define GEN_SHAPE_LO 3
`define GEN_CLK_STANDBY_BIT 2
`define GEN_CLK_ON_OUT1_BIT 1
`define GEN_MODE_BIT 0

// config_clock_and_match fields
`define CLK_DIV_HI 7
`define CLK_DIV_LO 5
`define MATCH_CAP_HI 4
`define MATCH_CAP_LO 0

// config_emulation fields
`define EMU_ENABLE_BIT 7
`define EMU_FSK_BIT 6
`define EMU_PWR_HI 5
`define EMU_PWR_LO 4
`define EMU_HDEV_BIT 3
`define EMU_CHAN_HI 2
`define EMU_CHAN_LO 0

// analog shaping codes
`define SHAPE_OPEN_EXT 2'h0
`define SHAPE_SLOW 2'h1
`define SHAPE_FAST 2'h2
`define SHAPE_OFF 2'h3

// general output select code that carries the crystal clock
`define OUT1_SEL_CLOCK 3'h2

// emulation power reduction in dB below maximum
`define PWR_RED_0 4'h0
`define PWR_RED_1 4'h3
`define PWR_RED_2 4'h6
`define PWR_RED_3 4'ha

// preset divide ratios, scaled by 100000
`define RATIO_NONE 22'h000000
`define RATIO_CH1 22'h1e0a6e
`define RATIO_CH2 22'h295a6d
`define RATIO_CH3 22'h25317c
`define RATIO_CH4 22'h27dd14
`define RATIO_CH5 22'h237a08
`define RATIO_CH6 22'h20e6da
`define RATIO_CH7 22'h2961c0

// clock output divide ratios (cycles of the reference per output period)
`define DIV_BY_1 5'h01
`define DIV_BY_2 5'h02
`define DIV_BY_4 5'h04
`define DIV_BY_8 5'h08
`define DIV_BY_16 5'h10

`endif

//--- logic/crystal_clock_divider.v
// divider that derives the gated clock output from the reference clock
`timescale 1ns/1ps
`include "tx_config_defines.vh"

module crystal_clock_divider (
    // clock and reset
    input wire clk,
    input wire srst,
    // control
    input wire run,
    input wire [2:0] div_code,
    // outputs
    output reg tick_reg,
    output reg wave_reg
);

    reg [4:0] count_reg;
    reg [4:0] count_next;
    wire [4:0] ratio;
    wire [4:0] half;

    // ratio decode: codes 1xx all give sixteen
    function [4:0] ratio_of;
        input [2:0] code;
        begin
            case (code)
                3'h0: ratio_of = `DIV_BY_1;
                3'h1: ratio_of = `DIV_BY_2;
                3'h2: ratio_of = `DIV_BY_4;
                3'h3: ratio_of = `DIV_BY_8;
                default: ratio_of = `DIV_BY_16;
            endcase
        end
    endfunction

    assign ratio = ratio_of(div_code);
    assign half = {1'b0, ratio[4:1]};

    // next count wraps at the ratio
    always @* begin
        count_next = count_reg + 5'h01;
        if (count_next >= ratio) begin
            count_next = 5'h00;
        end
    end

    // counter, tick and square wave; held low while stopped
    always @(posedge clk) begin
        if (srst || !run) begin
            count_reg <= 5'h00;
            tick_reg <= 1'b0;
            wave_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            tick_reg <= (count_next == 5'h00);
            if (ratio == `DIV_BY_1) begin
                wave_reg <= 1'b1; // undivided: steady high, tick every cycle
            end else begin
                wave_reg <= (count_next < half);
            end
        end
    end

endmodule // crystal_clock_divider

//--- logic/tx_config_register_bank.v
// identification and configuration register bank of the transmitter
`timescale 1ns/1ps
`include "tx_config_defines.vh"

module tx_config_register_bank #(
    parameter [7:0] IDENT_CODE = 8'h5c // arbitrary neutral identification value
) (
    // clock and reset
    input wire clk,
    input wire srst,
    // register access port from the serial control logic
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata_reg,
    output reg reg_rvalid_reg,
    // device state from neighbouring logic
    input wire standby,
    input wire [2:0] output_one_select,
    input wire out1_alt_value,
    // general output one
    output reg general_output_one_reg,
    output reg out1_drive_boost_reg,
    // synthesizer and modulation
    output reg pll_bw_high_reg,
    output reg tx_fsk_reg,
    output reg fsk_dev_high_reg,
    output reg emulation_active_reg,
    output reg [21:0] preset_ratio_reg,
    output reg preset_valid_reg,
    // power amplifier
    output reg [3:0] power_reduction_db_reg,
    output reg [4:0] match_cap_reg,
    // analog shaping
    output reg shaping_bias_pin_open_reg,
    output reg pulse_extension_reg,
    output reg shaping_enable_reg,
    output reg shaping_fast_reg,
    // crystal clock output
    output reg clock_out_active_reg,
    output reg clock_out_tick_reg,
    output reg clock_out_wave_reg
);

    reg [7:0] config_general_reg;
    reg [7:0] config_clock_and_match_reg;
    reg [7:0] config_emulation_reg;
    reg [7:0] rdata_next;
    reg clock_run_reg;
    wire div_tick;
    wire div_wave;
    wire emu_on;
    wire [1:0] shape_code;
    wire clk_on_out1;
    wire wr_general;
    wire wr_clock_and_match;
    wire wr_emulation;

    // preset ratio table of the emulation channels
    function [21:0] preset_of;
        input [2:0] chan;
        begin
            case (chan)
                3'h1: preset_of = `RATIO_CH1;
                3'h2: preset_of = `RATIO_CH2;
                3'h3: preset_of = `RATIO_CH3;
                3'h4: preset_of = `RATIO_CH4;
                3'h5: preset_of = `RATIO_CH5;
                3'h6: preset_of = `RATIO_CH6;
                3'h7: preset_of = `RATIO_CH7;
                default: preset_of = `RATIO_NONE;
            endcase
        end
    endfunction

    // power reduction table
    function [3:0] reduction_of;
        input [1:0] code;
        begin
            case (code)
                2'h0: reduction_of = `PWR_RED_0;
                2'h1: reduction_of = `PWR_RED_1;
                2'h2: reduction_of = `PWR_RED_2;
                default: reduction_of = `PWR_RED_3;
            endcase
        end
    endfunction

    // address compare shared by the write strobes
    function is_addr;
        input [7:0] addr;
        input [7:0] target;
        begin
            is_addr = (addr == target);
        end
    endfunction

    // write strobes; identification and unmapped offsets have none
    assign wr_general = reg_wr && is_addr(reg_addr, `ADDR_CONFIG_GENERAL);
    assign wr_clock_and_match = reg_wr && is_addr(reg_addr, `ADDR_CONFIG_CLOCK_AND_MATCH);
    assign wr_emulation = reg_wr && is_addr(reg_addr, `ADDR_CONFIG_EMULATION);

    // general configuration; the unused bit is never stored
    always @(posedge clk) begin
        if (srst) begin
            config_general_reg <= `RST_CONFIG_GENERAL;
        end else if (wr_general) begin
            config_general_reg <= reg_wdata & `MASK_CONFIG_GENERAL;
        end
    end

    // clock divider code and matching capacitor code
    always @(posedge clk) begin
        if (srst) begin
            config_clock_and_match_reg <= `RST_CONFIG_CLOCK_AND_MATCH;
        end else if (wr_clock_and_match) begin
            config_clock_and_match_reg <= reg_wdata;
        end
    end

    // emulation settings
    always @(posedge clk) begin
        if (srst) begin
            config_emulation_reg <= `RST_CONFIG_EMULATION;
        end else if (wr_emulation) begin
            config_emulation_reg <= reg_wdata;
        end
    end

    // read multiplexer; unmapped offsets read zero
    always @* begin
        case (reg_addr)
            `ADDR_IDENTIFICATION: rdata_next = IDENT_CODE;
            `ADDR_CONFIG_GENERAL: rdata_next = config_general_reg & `MASK_CONFIG_GENERAL;
            `ADDR_CONFIG_CLOCK_AND_MATCH: rdata_next = config_clock_and_match_reg;
            `ADDR_CONFIG_EMULATION: rdata_next = config_emulation_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    // read valid pulse, one cycle after the strobe
    always @(posedge clk) begin
        if (srst) begin
            reg_rvalid_reg <= 1'b0;
        end else begin
            reg_rvalid_reg <= reg_rd;
        end
    end

    // read data, loaded on each read and held between reads
    always @(posedge clk) begin
        if (srst) begin
            reg_rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_reg <= rdata_next;
        end
    end

    // field decode
    assign emu_on = config_emulation_reg[`EMU_ENABLE_BIT];
    assign shape_code = config_general_reg[`GEN_SHAPE_HI:`GEN_SHAPE_LO];
    assign clk_on_out1 = config_general_reg[`GEN_CLK_ON_OUT1_BIT] &&
        (output_one_select == `OUT1_SEL_CLOCK);

    // crystal clock runs while active, or in standby when asked to
    always @(posedge clk) begin
        if (srst) begin
            clock_run_reg <= 1'b0;
        end else begin
            clock_run_reg <= !standby || config_general_reg[`GEN_CLK_STANDBY_BIT];
        end
    end

    crystal_clock_divider u_divider (
        .clk(clk),
        .srst(srst),
        .run(clock_run_reg),
        .div_code(config_clock_and_match_reg[`CLK_DIV_HI:`CLK_DIV_LO]),
        .tick_reg(div_tick),
        .wave_reg(div_wave)
    );

    // drive strength and loop bandwidth
    always @(posedge clk) begin
        if (srst) begin
            out1_drive_boost_reg <= 1'b0;
            pll_bw_high_reg <= 1'b0;
        end else begin
            out1_drive_boost_reg <= config_general_reg[`GEN_DRIVE_BOOST_BIT];
            pll_bw_high_reg <= config_general_reg[`GEN_PLL_BW_BIT];
        end
    end

    // matching capacitor code
    always @(posedge clk) begin
        if (srst) begin
            match_cap_reg <= 5'h00;
        end else begin
            match_cap_reg <= config_clock_and_match_reg[`MATCH_CAP_HI:`MATCH_CAP_LO];
        end
    end

    // crystal clock outputs, retimed so every output leaves a flop of this module
    always @(posedge clk) begin
        if (srst) begin
            clock_out_active_reg <= 1'b0;
            clock_out_tick_reg <= 1'b0;
            clock_out_wave_reg <= 1'b0;
        end else begin
            clock_out_active_reg <= clock_run_reg;
            clock_out_tick_reg <= div_tick;
            clock_out_wave_reg <= div_wave;
        end
    end

    // general output one: divided clock only with the clock select code
    always @(posedge clk) begin
        if (srst) begin
            general_output_one_reg <= 1'b0;
        end else if (clk_on_out1) begin
            general_output_one_reg <= div_wave;
        end else begin
            general_output_one_reg <= out1_alt_value;
        end
    end

    // shaping pin and pulse extension, both only for the open code
    always @(posedge clk) begin
        if (srst) begin
            shaping_bias_pin_open_reg <= 1'b1;
            pulse_extension_reg <= 1'b1;
        end else begin
            shaping_bias_pin_open_reg <= (shape_code == `SHAPE_OPEN_EXT);
            pulse_extension_reg <= (shape_code == `SHAPE_OPEN_EXT);
        end
    end

    // shaping time constant: slow or fast, none for the open and off codes
    always @(posedge clk) begin
        if (srst) begin
            shaping_enable_reg <= 1'b0;
            shaping_fast_reg <= 1'b0;
        end else begin
            shaping_enable_reg <= (shape_code == `SHAPE_SLOW) ||
                (shape_code == `SHAPE_FAST);
            shaping_fast_reg <= (shape_code == `SHAPE_FAST);
        end
    end

    // modulation select: emulation overrides the general mode bit
    always @(posedge clk) begin
        if (srst) begin
            emulation_active_reg <= 1'b0;
            tx_fsk_reg <= 1'b0;
        end else begin
            emulation_active_reg <= emu_on;
            if (emu_on) begin
                tx_fsk_reg <= config_emulation_reg[`EMU_FSK_BIT];
            end else begin
                tx_fsk_reg <= config_general_reg[`GEN_MODE_BIT];
            end
        end
    end

    // emulation presets, all cleared while emulation is off
    always @(posedge clk) begin
        if (srst) begin
            fsk_dev_high_reg <= 1'b0;
            power_reduction_db_reg <= 4'h0;
            preset_ratio_reg <= 22'h000000;
            preset_valid_reg <= 1'b0;
        end else begin
            if (emu_on) begin
                fsk_dev_high_reg <= config_emulation_reg[`EMU_HDEV_BIT];
                power_reduction_db_reg <=
                    reduction_of(config_emulation_reg[`EMU_PWR_HI:`EMU_PWR_LO]);
                preset_ratio_reg <=
                    preset_of(config_emulation_reg[`EMU_CHAN_HI:`EMU_CHAN_LO]);
                preset_valid_reg <=
                    (config_emulation_reg[`EMU_CHAN_HI:`EMU_CHAN_LO] != 3'h0);
            end else begin
                fsk_dev_high_reg <= 1'b0;
                power_reduction_db_reg <= 4'h0;
                preset_ratio_reg <= 22'h000000;
                preset_valid_reg <= 1'b0;
            end
        end
    end

endmodule // tx_config_register_bank

//--- testbench/tx_config_props.sv
// concurrent checks on the config bank ports
`timescale 1ns/1ps
module tx_config_props #(
    parameter [7:0] IDENT_CODE = 8'h5c
) (
    // clock and reset
    input wire clk,
    input wire srst,
    // register port
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata_reg,
    input wire reg_rvalid_reg,
    // decoded outputs
    input wire out1_drive_boost_reg,
    input wire pll_bw_high_reg,
    input wire [4:0] match_cap_reg,
    input wire emulation_active_reg,
    input wire fsk_dev_high_reg,
    input wire [3:0] power_reduction_db_reg,
    input wire preset_valid_reg,
    input wire [21:0] preset_ratio_reg,
    input wire clock_out_active_reg,
    input wire clock_out_tick_reg,
    input wire clock_out_wave_reg
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    // read answers
    AST_RVALID: assert property (reg_rd |=> reg_rvalid_reg)
        else $error("read without valid pulse");
    AST_RVALID_CAUSE: assert property (reg_rvalid_reg |-> $past(reg_rd))
        else $error("valid pulse without read");
    AST_IDENT: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata_reg == IDENT_CODE)
        else $error("identification read wrong");
    AST_UNUSED_BIT: assert property (reg_rd && reg_addr == 8'h01 |=> !reg_rdata_reg[7])
        else $error("unused bit reads one");
    // writes reach decoded outputs two cycles later
    AST_DRIVE_BW: assert property (reg_wr && reg_addr == 8'h01 |-> ##2
        {out1_drive_boost_reg, pll_bw_high_reg} == $past(reg_wdata[6:5], 2))
        else $error("drive or bandwidth not updated");
    AST_MATCH: assert property (reg_wr && reg_addr == 8'h02 |-> ##2
        match_cap_reg == $past(reg_wdata[4:0], 2))
        else $error("matching code not updated");
    AST_EMU: assert property (reg_wr && reg_addr == 8'h03 |-> ##2
        emulation_active_reg == $past(reg_wdata[7], 2))
        else $error("emulation enable not updated");
    // emulation-only outputs and preset
    AST_EMU_OFF: assert property (!emulation_active_reg |->
        power_reduction_db_reg == 4'h0 && !fsk_dev_high_reg && !preset_valid_reg)
        else $error("emulation output while off");
    AST_PRESET: assert property (preset_valid_reg == (preset_ratio_reg != 22'h0))
        else $error("preset valid and ratio disagree");
    // stopped clock output stays quiet
    AST_CLK_STOP: assert property (!clock_out_active_reg [*6] |->
        !clock_out_tick_reg && !clock_out_wave_reg)
        else $error("clock output runs while stopped");
endmodule // tx_config_props

//--- testbench/tx_host_model.sv
// host model driving the register strobe port
`timescale 1ns/1ps
module tx_host_model (
    // clock
    input wire clk,
    // strobe port
    output reg reg_wr,
    output reg reg_rd,
    output reg [7:0] reg_addr,
    output reg [7:0] reg_wdata,
    input wire [7:0] reg_rdata_reg,
    input wire reg_rvalid_reg
);
    // idle strobes at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // one-cycle write, bus inverted once released
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    // one-cycle read, data taken at the edge that samples the valid pulse
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk);
        d = (reg_rvalid_reg === 1'b1) ? reg_rdata_reg : 8'hxx;
    endtask
endmodule // tx_host_model

//--- testbench/tx_config_register_bank_tb.sv
// self-checking bench of the config register bank
`timescale 1ns/1ps
module tx_config_register_bank_tb;
    localparam [7:0] IDENT = 8'h3b; // arbitrary identification value
    reg clk = 1'b0;
    reg srst = 1'b1;
    reg standby = 1'b0;
    reg [2:0] output_one_select = 3'h0;
    reg out1_alt_value = 1'b0;
    wire reg_wr, reg_rd, reg_rvalid_reg, general_output_one_reg, out1_drive_boost_reg;
    wire [7:0] reg_addr, reg_wdata, reg_rdata_reg;
    wire pll_bw_high_reg, tx_fsk_reg, fsk_dev_high_reg, emulation_active_reg, preset_valid_reg;
    wire [21:0] preset_ratio_reg;
    wire [3:0] power_reduction_db_reg;
    wire [4:0] match_cap_reg;
    wire shaping_bias_pin_open_reg, pulse_extension_reg, shaping_enable_reg, shaping_fast_reg;
    wire clock_out_active_reg, clock_out_tick_reg, clock_out_wave_reg;
    wire [3:0] shp = {shaping_bias_pin_open_reg, pulse_extension_reg, shaping_enable_reg,
        shaping_fast_reg};
    integer bad_count = 0;
    integer checks = 0;
    integer i;
    logic [7:0] rv;
    logic [31:0] t, w, g;
    logic [21:0] ratio [0:7];
    logic [3:0] pw [0:3];

    // design and host
    tx_config_register_bank #(.IDENT_CODE(IDENT)) u_tx_config_register_bank (.*);
    tx_host_model u_tx_host_model (.*);

    // 50 MHz clock
    always #10 clk = ~clk;

    // compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // settle past n edges
    task tick(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // count tick, wave and output one highs over 64 cycles
    task count64;
        t = 0;
        w = 0;
        g = 0;
        repeat (64) begin
            @(posedge clk);
            #1;
            t = t + clock_out_tick_reg;
            w = w + clock_out_wave_reg;
            g = g + general_output_one_reg;
        end
    endtask
    // verdict and end of run
    task give_verdict;
        if (bad_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        #200000;
        bad_count = bad_count + 1;
        give_verdict;
    end

    // test sequence
    initial begin
        ratio[0] = 22'h000000;
        ratio[1] = 22'h1e0a6e;
        ratio[2] = 22'h295a6d;
        ratio[3] = 22'h25317c;
        ratio[4] = 22'h27dd14;
        ratio[5] = 22'h237a08;
        ratio[6] = 22'h20e6da;
        ratio[7] = 22'h2961c0;
        pw[0] = 4'h0;
        pw[1] = 4'h3;
        pw[2] = 4'h6;
        pw[3] = 4'ha;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        // reset contents, identification and unmapped reads
        for (i = 0; i < 6; i++) begin
            u_tx_host_model.rd(i == 5 ? 8'hff : i[7:0], rv);
            chk(rv, i == 0 ? IDENT : 8'h00);
        end
        u_tx_host_model.wr(8'h00, 8'hff);
        u_tx_host_model.rd(8'h00, rv);
        chk(rv, IDENT);
        // general config bits, unused bit dropped
        u_tx_host_model.wr(8'h01, 8'hd1);
        u_tx_host_model.rd(8'h01, rv);
        chk(rv, 8'h51);
        chk({out1_drive_boost_reg, pll_bw_high_reg, tx_fsk_reg}, 3'b101);
        u_tx_host_model.wr(8'h01, 8'ha0);
        u_tx_host_model.rd(8'h01, rv);
        chk(rv, 8'h20);
        chk({out1_drive_boost_reg, pll_bw_high_reg, tx_fsk_reg}, 3'b010);
        // every shaping code
        for (i = 0; i < 4; i++) begin
            u_tx_host_model.wr(8'h01, {3'h0, i[1:0], 3'h0});
            tick(1);
            chk(shp, (16'h032c >> (4 * i)) & 16'hf);
        end
        // every emulation channel and power code
        for (i = 0; i < 8; i++) begin
            u_tx_host_model.wr(8'h03, {1'b1, i[0], i[1:0], i[0], i[2:0]});
            tick(1);
            chk({emulation_active_reg, tx_fsk_reg, fsk_dev_high_reg, power_reduction_db_reg},
                {1'b1, i[0], i[0], pw[i[1:0]]});
            chk({preset_valid_reg, preset_ratio_reg}, {i != 0, ratio[i]});
        end
        u_tx_host_model.wr(8'h03, 8'h7f);
        tick(1);
        chk({emulation_active_reg, tx_fsk_reg, fsk_dev_high_reg, power_reduction_db_reg,
            preset_valid_reg, preset_ratio_reg}, 32'h0);
        // every divider code and eight matching codes
        for (i = 0; i < 8; i++) begin
            u_tx_host_model.wr(8'h02, {i[2:0], 5'h1f ^ i[4:0]});
            tick(20);
            chk(match_cap_reg, 5'h1f ^ i[4:0]);
            count64;
            chk(t, i > 3 ? 4 : 64 >> i);
            chk(w, i == 0 ? 64 : 32);
        end
        // divided clock on general output one
        @(posedge clk);
        output_one_select <= 3'h2;
        u_tx_host_model.wr(8'h01, 8'h02);
        tick(20);
        count64;
        chk(g, 32);
        @(posedge clk);
        out1_alt_value <= 1'b1;
        output_one_select <= 3'h3;
        tick(4);
        count64;
        chk(g, 64);
        @(posedge clk);
        output_one_select <= 3'h2;
        u_tx_host_model.wr(8'h01, 8'h00);
        tick(4);
        count64;
        chk(g, 64);
        // standby stops the clock unless kept running
        @(posedge clk);
        standby <= 1'b1;
        tick(8);
        count64;
        chk(clock_out_active_reg, 1'b0);
        chk(t, 0);
        u_tx_host_model.wr(8'h01, 8'h04);
        tick(20);
        count64;
        chk(clock_out_active_reg, 1'b1);
        chk(t, 4);
        give_verdict;
    end
endmodule // tx_config_register_bank_tb

bind tx_config_register_bank tx_config_props #(.IDENT_CODE(IDENT_CODE)) u_tx_config_props (.*);
